// File: sep_consts.svh
// Constants of the serial EEPROM pin front end.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

`define SEP_MEM_DEPTH    4096
`define SEP_MEM_AW       12
`define SEP_IDP_DEPTH    32
`define SEP_IDP_AW       5
`define SEP_BIT_CNT_W    3
`define SEP_BIT_LAST     3'h7
`define SEP_BIT_FIRST    3'h0
`define SEP_BIT_STEP     3'h1
`define SEP_BYTE_RST     8'h00
`define SEP_BP_RST       2'h0
`define SEP_BP_HI_POS    1
`define SEP_BP_LO_POS    0
`define SEP_SYNC_FIRST   0
`define SEP_SYNC_SECOND  1
`define SEP_SYNC_EDGE    2

`endif

// File: sep_pkg.sv
// Types shared by the serial EEPROM pin front end.
// Assumes sep_consts.svh is on the include path.
`include "sep_consts.svh"

package sep_pkg;

    typedef logic [7:0] sep_byte_t;

    // System-clock state
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sck_sync;
        logic [1:0] hold_sync;
        logic [1:0] wp_sync;
        logic [2:0] rx_sync;
        logic [2:0] take_sync;
        logic       armed;
        logic       hold;
        sep_byte_t  rx_byte;
        logic       rx_valid;
        sep_byte_t  tx_data;
        logic       tx_full;
        logic [1:0] bp;
        logic       id_lock;
        sep_byte_t  rdata;
    } sep_sys_t;

    // Link rising edge, cleared by deselect
    typedef struct packed {
        logic [`SEP_BIT_CNT_W-1:0] cnt;
        logic [6:0]                sh;
        logic                      started;
    } sep_rx_frame_t;

    // Link rising edge, cleared by reset only
    typedef struct packed {
        sep_byte_t buf0;
        sep_byte_t buf1;
        logic      tog;
    } sep_rx_data_t;

    // Link falling edge, cleared by deselect
    typedef struct packed {
        logic       out;
        logic [6:0] sh;
    } sep_tx_frame_t;

endpackage

// File: sep_pins.sv
// Serial EEPROM pin front end: select, hold, shift in and out, protect, arrays.
// Assumes a core on sys_clk_i decodes instructions and runs write cycles;
// the serial clock is a clock port of its own and may stop outside frames.
`include "sep_consts.svh"

// Behaviour
// - Byte array of 4096 locations, each eight bits wide.
// - Separate 32-byte identification page, lockable to read only until the next reset.
// - Selected only while the active-low select input is low.
// - Serial communication stops while the active-low hold input is low.
// - Serial output bit changes on each falling serial clock edge.
// - Serial input sampled on each rising serial clock edge.
// - Select high deselects and floats the serial output.
// - Deselected means standby unless a write cycle runs; selected means active.
// - No instruction accepted until select has fallen after power-up.
// - Hold pauses without deselecting; the bit sequence resumes afterwards.
// - During hold the output floats; data and clock are ignored.
// - Write-protect input freezes the two block-protect bits.
// - All bytes travel most significant bit first, both directions.
// - Works with clock idle low or idle high; same edges used.
// - Hold flag changes only while the serial clock is low, except that deselect clears it at once; the hold pin stops shifting and floats the output at once.
// - Deselect during hold resets the front end logic.
module sep_pins
    import sep_pkg::*;
#(
    parameter int MEM_DEPTH = `SEP_MEM_DEPTH,
    parameter int IDP_DEPTH = `SEP_IDP_DEPTH
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   sck_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   mosi_i,
    input  wire logic                   hold_n_i,
    input  wire logic                   wp_n_i,
    output logic                        miso_o,
    output logic                        miso_oe_o,
    input  wire logic                   write_busy_i,
    output logic                        selected_o,
    output logic                        hold_o,
    output logic                        active_o,
    output logic                        standby_o,
    output sep_byte_t                   rx_byte_o,
    output logic                        rx_valid_o,
    input  wire logic                   tx_valid_i,
    input  wire sep_byte_t              tx_data_i,
    output logic                        tx_ready_o,
    input  wire logic                   bp_we_i,
    input  wire logic [1:0]             bp_wdata_i,
    output logic                        block_protect_hi_o,
    output logic                        block_protect_lo_o,
    input  wire logic                   mem_en_i,
    input  wire logic                   mem_we_i,
    input  wire logic                   mem_id_i,
    input  wire logic [`SEP_MEM_AW-1:0] mem_addr_i,
    input  wire sep_byte_t              mem_wdata_i,
    output sep_byte_t                   mem_rdata_o,
    input  wire logic                   id_lock_i,
    output logic                        id_locked_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    sep_sys_t      sys_q;
    sep_sys_t      sys_d;
    sep_rx_frame_t rxf_q;
    sep_rx_frame_t rxf_d;
    sep_rx_data_t  rxd_q;
    sep_rx_data_t  rxd_d;
    sep_tx_frame_t txf_q;
    sep_tx_frame_t txf_d;
    logic          take_tog_q;
    logic          take_tog_d;
    logic          link_rst_b;
    logic          link_run;
    logic          cs_high_s;
    logic          rx_edge;
    logic          take_edge;
    logic          tx_load;
    sep_byte_t     mem_rd;

    sep_byte_t mem_q [MEM_DEPTH];
    sep_byte_t idp_q [IDP_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // Link reset and run level

    // deselect clears frame state
    // Armed only moves while select is high, so the link sees it steady.
    assign link_rst_b = rst_b_i & sys_q.armed & ~cs_n_i;
    assign link_run   = link_rst_b & hold_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // Link rising edge: receive

    always_comb begin
        rxf_d = rxf_q;
        rxd_d = rxd_q;
        if (hold_n_i) begin
            rxf_d.sh      = {rxf_q.sh[5:0], mosi_i};
            rxf_d.cnt     = rxf_q.cnt + `SEP_BIT_STEP;
            rxf_d.started = 1'b1;
        end
        // Ping-pong halves give the slow side two bytes of time.
        if (link_run && rxf_q.cnt == `SEP_BIT_LAST) begin
            if (rxd_q.tog) begin
                rxd_d.buf1 = {rxf_q.sh, mosi_i};
            end else begin
                rxd_d.buf0 = {rxf_q.sh, mosi_i};
            end
            rxd_d.tog = ~rxd_q.tog;
        end
    end

    always_ff @(posedge sck_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            rxf_q <= '0;
        end else begin
            rxf_q <= rxf_d;
        end
    end

    always_ff @(posedge sck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rxd_q <= '0;
        end else begin
            rxd_q <= rxd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link falling edge: transmit

    // Start of byte only after a rising edge, so idle-high clocks load late
    assign tx_load = link_run && rxf_q.started && rxf_q.cnt == `SEP_BIT_FIRST;

    always_comb begin
        txf_d      = txf_q;
        take_tog_d = take_tog_q;
        if (hold_n_i) begin
            if (tx_load) begin
                txf_d.out  = sys_q.tx_data[7];
                txf_d.sh   = sys_q.tx_data[6:0];
                take_tog_d = ~take_tog_q;
            end else begin
                txf_d.out = txf_q.sh[6];
                txf_d.sh  = {txf_q.sh[5:0], 1'b0};
            end
        end
    end

    always_ff @(negedge sck_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            txf_q <= '0;
        end else begin
            txf_q <= txf_d;
        end
    end

    always_ff @(negedge sck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            take_tog_q <= 1'b0;
        end else begin
            take_tog_q <= take_tog_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System side

    assign cs_high_s = sys_q.cs_sync[`SEP_SYNC_SECOND];
    assign rx_edge   = sys_q.rx_sync[`SEP_SYNC_SECOND] ^ sys_q.rx_sync[`SEP_SYNC_EDGE];
    assign take_edge = sys_q.take_sync[`SEP_SYNC_SECOND] ^ sys_q.take_sync[`SEP_SYNC_EDGE];

    always_comb begin
        mem_rd = `SEP_BYTE_RST;
        if (mem_id_i) begin
            mem_rd = idp_q[mem_addr_i[`SEP_IDP_AW-1:0]];
        end else begin
            mem_rd = mem_q[mem_addr_i];
        end
    end

    always_comb begin
        sys_d           = sys_q;
        sys_d.cs_sync   = {sys_q.cs_sync[0], cs_n_i};
        sys_d.sck_sync  = {sys_q.sck_sync[0], sck_i};
        sys_d.hold_sync = {sys_q.hold_sync[0], hold_n_i};
        sys_d.wp_sync   = {sys_q.wp_sync[0], wp_n_i};
        sys_d.rx_sync   = {sys_q.rx_sync[1:0], rxd_q.tog};
        sys_d.take_sync = {sys_q.take_sync[1:0], take_tog_q};
        sys_d.rx_valid  = 1'b0;
        if (cs_high_s) begin
            sys_d.armed = 1'b1;
        end
        if (cs_high_s) begin
            sys_d.hold = 1'b0;
        end else if (!sys_q.sck_sync[`SEP_SYNC_SECOND]) begin
            sys_d.hold = ~sys_q.hold_sync[`SEP_SYNC_SECOND];
        end
        if (rx_edge) begin
            sys_d.rx_valid = 1'b1;
            sys_d.rx_byte  = sys_q.rx_sync[`SEP_SYNC_EDGE] ? rxd_q.buf1 : rxd_q.buf0;
        end
        // Take before accept, so a new byte is never dropped
        if (take_edge) begin
            sys_d.tx_full = 1'b0;
        end
        if (tx_valid_i && !sys_q.tx_full) begin
            sys_d.tx_data = tx_data_i;
            sys_d.tx_full = 1'b1;
        end
        if (bp_we_i && sys_q.wp_sync[`SEP_SYNC_SECOND]) begin
            sys_d.bp = bp_wdata_i;
        end
        if (id_lock_i) begin
            sys_d.id_lock = 1'b1;
        end
        if (mem_en_i && !mem_we_i) begin
            sys_d.rdata = mem_rd;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // Sync starts low: a select held low through reset must not arm
            sys_q         <= '0;
            sys_q.bp      <= `SEP_BP_RST;
        end else if (clk_en_i) begin
            sys_q <= sys_d;
        end
    end

    // Arrays carry no reset, as a stored image would not
    always_ff @(posedge sys_clk_i) begin
        if (clk_en_i && mem_en_i && mem_we_i) begin
            if (!mem_id_i) begin
                mem_q[mem_addr_i] <= mem_wdata_i;
            end else if (!sys_q.id_lock) begin
                idp_q[mem_addr_i[`SEP_IDP_AW-1:0]] <= mem_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign miso_o             = txf_q.out;
    // float during hold
    // Pin hold cuts at once; end of hold waits for the clock-low check.
    assign miso_oe_o          = link_run & ~sys_q.hold;
    assign selected_o         = sys_q.armed & ~cs_high_s;
    assign hold_o             = sys_q.hold;
    assign active_o           = selected_o | write_busy_i;
    assign standby_o          = ~active_o;
    assign rx_byte_o          = sys_q.rx_byte;
    assign rx_valid_o         = sys_q.rx_valid;
    // Refill must beat the next byte boundary or the old byte repeats.
    assign tx_ready_o         = ~sys_q.tx_full;
    assign block_protect_hi_o = sys_q.bp[`SEP_BP_HI_POS];
    assign block_protect_lo_o = sys_q.bp[`SEP_BP_LO_POS];
    assign mem_rdata_o        = sys_q.rdata;
    assign id_locked_o        = sys_q.id_lock;

endmodule

// File: sep_pins_sva.sv
// Checker of the pin front end, system clock side.
// Assumes the sep_pins ports; bound to every instance below.
module sep_pins_sva (
    input wire logic       sys_clk_i,
    input wire logic       rst_b_i,
    input wire logic       clk_en_i,
    input wire logic       cs_n_i,
    input wire logic       hold_n_i,
    input wire logic       wp_n_i,
    input wire logic       write_busy_i,
    input wire logic       bp_we_i,
    input wire logic [1:0] bp_wdata_i,
    input wire logic       id_lock_i,
    input wire logic       miso_oe_o,
    input wire logic       selected_o,
    input wire logic       hold_o,
    input wire logic       active_o,
    input wire logic       standby_o,
    input wire logic       block_protect_hi_o,
    input wire logic       block_protect_lo_o,
    input wire logic       id_locked_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////
    // Three samples, since the pins pass a two-flop sync
    sequence s_cs_hi; (cs_n_i && clk_en_i) [*3]; endsequence
    sequence s_wp_hi; (wp_n_i && clk_en_i) [*3] ##0 bp_we_i; endsequence
    sequence s_wp_lo; (!wp_n_i && clk_en_i) [*3] ##0 bp_we_i; endsequence
    property p_oe_cs; cs_n_i |-> !miso_oe_o; endproperty
    property p_oe_hold; !hold_n_i |-> !miso_oe_o; endproperty
    property p_mode; active_o == (selected_o | write_busy_i) && standby_o != active_o;
    endproperty
    property p_desel; s_cs_hi |=> !selected_o; endproperty
    property p_hold_clr; s_cs_hi |=> !hold_o; endproperty
    property p_bp_load;
        s_wp_hi |=> {block_protect_hi_o, block_protect_lo_o} == $past(bp_wdata_i);
    endproperty
    property p_bp_keep; s_wp_lo |=> $stable({block_protect_hi_o, block_protect_lo_o});
    endproperty
    property p_lock; id_lock_i && clk_en_i || id_locked_o |=> id_locked_o; endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("output on while deselected");
    a_oe_hold: assert property (p_oe_hold) else $error("output on in hold");
    a_mode: assert property (p_mode) else $error("power mode wrong");
    a_desel: assert property (p_desel) else $error("selected with select high");
    a_hold_clr: assert property (p_hold_clr) else $error("hold kept when deselected");
    a_bp_load: assert property (p_bp_load) else $error("protect bits not loaded");
    a_bp_keep: assert property (p_bp_keep) else $error("protect bits changed");
    a_lock: assert property (p_lock) else $error("page lock lost");
endmodule

bind sep_pins sep_pins_sva u_sva (.*);

// File: sep_master.sv
// Serial bus master model, clock mode 0 or 3, 15 ns serial clock.
// Assumes the bench calls frame; clock stands still between frames.
module sep_master
    import sep_pkg::*;
(
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    output logic      hold_n_o,
    input  wire logic miso_i
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////
    // Select low at power-up on purpose
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b0;
        mosi_o = 1'b0;
        hold_n_o = 1'b1;
    end
    task automatic pause();
        #200 hold_n_o = 1'b0;
        #200;
        repeat (4) begin
            #15 sck_o = ~sck_o;
            mosi_o = ~mosi_o;
        end
        #200 hold_n_o = 1'b1;
        #200;
    endtask
    task automatic frame(input logic m3, input sep_byte_t b0, input sep_byte_t b1,
                         input int hold_at, output sep_byte_t r1);
        logic [15:0] sh;
        sh = {b0, b1};
        r1 = 8'h00;
        cs_n_o = 1'b1;
        sck_o = m3;
        #200 cs_n_o = 1'b0;
        #20;
        for (int i = 15; i >= 0; i--) begin
            sck_o = 1'b0;
            if (i == hold_at) pause();
            mosi_o = sh[i];
            #7.5 sck_o = 1'b1;
            if (i < 8) r1[i] = miso_i;
            #7.5;
        end
        sck_o = m3;
        #20 cs_n_o = 1'b1;
        // Released line shows no stale bit
        mosi_o = ~mosi_o;
    endtask
endmodule

// File: sep_pins_tb.sv
// Bench of the pin front end: table of frames, then hold, power, protect, memory.
// Assumes the master model on the serial pins; system inputs driven here.
module sep_pins_tb
    import sep_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic      m3;
        sep_byte_t b0;
        sep_byte_t b1;
        sep_byte_t tx;
    } sep_row_t;
    sep_row_t rows [4] = '{'{1'b0, 8'ha5, 8'h3c, 8'h96}, '{1'b1, 8'h5a, 8'hc3, 8'h69},
                           '{1'b0, 8'h80, 8'h01, 8'hfe}, '{1'b1, 8'h01, 8'h80, 8'h7f}};
    logic sys_clk_i, rst_b_i, clk_en_i, wp_n_i, write_busy_i, tx_valid_i, bp_we_i, mem_en_i;
    logic mem_we_i, mem_id_i, id_lock_i, miso_o, miso_oe_o, selected_o, hold_o, active_o;
    logic standby_o, rx_valid_o, tx_ready_o, block_protect_hi_o, block_protect_lo_o;
    logic id_locked_o, hold_seen;
    logic [1:0] bp_wdata_i;
    logic [11:0] mem_addr_i;
    sep_byte_t tx_data_i, mem_wdata_i, rx_byte_o, mem_rdata_o, got;
    sep_byte_t rxq [$];
    wire logic sck_i, cs_n_i, mosi_i, hold_n_i, miso_w;
    int err_total, num_checks;
    assign miso_w = miso_oe_o ? miso_o : 1'bz;
    sep_pins dut (.*);
    sep_master m (.sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i), .hold_n_o(hold_n_i),
                  .miso_i(miso_w));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (rx_valid_o === 1'b1) rxq.push_back(rx_byte_o);
        if (hold_o === 1'b1) hold_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic send_tx(input sep_byte_t b);
        for (int n = 0; tx_ready_o !== 1'b1; n++) begin
            if (n > 50) begin
                err_total++;
                test_done();
            end
            @(posedge sys_clk_i);
        end
        tx_valid_i <= 1'b1;
        tx_data_i <= b;
        @(posedge sys_clk_i);
        tx_valid_i <= 1'b0;
    endtask
    task automatic run(input sep_row_t r, input int hold_at);
        send_tx(r.tx);
        // Refill well before the byte boundary
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk("tx ready full", tx_ready_o, 8'h00);
        rxq.delete();
        m.frame(r.m3, r.b0, r.b1, hold_at, got);
        repeat (8) @(posedge sys_clk_i);
        chk("tx ready taken", tx_ready_o, 8'h01);
        chk("rx count", 8'(rxq.size()), 8'h02);
        chk("rx first", rxq[0], r.b0);
        chk("rx second", rxq[1], r.b1);
        chk("tx byte", got, r.tx);
        $display("frame test done");
    endtask
    task automatic mem(input logic id, input logic we, input logic [11:0] a, sep_byte_t d);
        @(posedge sys_clk_i);
        {mem_en_i, mem_we_i, mem_id_i, mem_addr_i, mem_wdata_i} <= {1'b1, we, id, a, d};
        @(posedge sys_clk_i);
        mem_en_i <= 1'b0;
        #1;
    endtask
    task automatic bp_try(input logic wp, input logic [1:0] v);
        wp_n_i <= wp;
        repeat (3) @(posedge sys_clk_i);
        bp_we_i <= 1'b1;
        bp_wdata_i <= v;
        @(posedge sys_clk_i);
        bp_we_i <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {rst_b_i, clk_en_i, wp_n_i, write_busy_i, tx_valid_i, bp_we_i} = 6'h18;
        {mem_en_i, mem_we_i, mem_id_i, id_lock_i, hold_seen} = 5'h00;
        {bp_wdata_i, mem_addr_i, tx_data_i, mem_wdata_i} = '0;
        err_total = 0;
        num_checks = 0;
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        chk("selected", selected_o, 8'h00);
        foreach (rows[k]) run(rows[k], -1);
        run('{1'b0, 8'hc6, 8'h39, 8'h3a}, 3);
        chk("hold seen", hold_seen, 8'h01);
        @(posedge sys_clk_i);
        write_busy_i <= 1'b1;
        #1;
        chk("busy power", {active_o, standby_o}, 8'h02);
        @(posedge sys_clk_i);
        write_busy_i <= 1'b0;
        #1;
        chk("idle power", {active_o, standby_o}, 8'h01);
        bp_try(1'b1, 2'h2);
        chk("bp load", {block_protect_hi_o, block_protect_lo_o}, 8'h02);
        bp_try(1'b0, 2'h1);
        chk("bp frozen", {block_protect_hi_o, block_protect_lo_o}, 8'h02);
        $display("power and protect test done");
        mem(1'b0, 1'b1, 12'hfff, 8'ha3);
        mem(1'b0, 1'b1, 12'h000, 8'h5c);
        mem(1'b0, 1'b0, 12'hfff, 8'h00);
        chk("mem top", mem_rdata_o, 8'ha3);
        mem(1'b0, 1'b0, 12'h000, 8'h00);
        chk("mem base", mem_rdata_o, 8'h5c);
        mem(1'b1, 1'b1, 12'h01f, 8'h77);
        id_lock_i <= 1'b1;
        @(posedge sys_clk_i);
        id_lock_i <= 1'b0;
        mem(1'b1, 1'b1, 12'h01f, 8'h11);
        mem(1'b1, 1'b0, 12'h01f, 8'h00);
        chk("id page", mem_rdata_o, 8'h77);
        chk("id lock", id_locked_o, 8'h01);
        $display("memory test done");
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        chk("rst selected", selected_o, 8'h00);
        chk("rst ready", tx_ready_o, 8'h01);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        run(rows[1], -1);
        $display("reset test done");
        test_done();
    end
endmodule
